/* File: spb_pkg.sv */
// shared constants for the port-b spi master and rate generator
package spb_pkg;
   localparam logic [2:0] MODE_SHIFT = 3'h0;
   localparam logic [2:0] MODE_UART8 = 3'h1;
   localparam logic [2:0] MODE_SPI   = 3'h4;
   localparam int unsigned SPI_DIV_FAST = 4;
   localparam int unsigned SPI_DIV_SLOW = 12;
   localparam int unsigned PRESCALE_DIV = 12;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned UART_DIV     = 32;
   localparam logic       BIT_ORDER_RST = 1'b1;
   localparam logic [7:0] RATE_RST      = 8'h00;
   localparam logic [7:0] RATE_MAX      = 8'hFF;
   localparam logic [3:0] BITS_LAST     = 4'h7;
   typedef enum logic [1:0] {
      SPB_IDLE = 2'b00,
      SPB_LOW  = 2'b01,
      SPB_HIGH = 2'b11
   } spb_state_e;
endpackage

/* File: spb_rate_gen.sv */
// 8-bit auto-reload rate generator with clock-out toggle
module spb_rate_gen #(
   parameter int unsigned PRE_DIV = spb_pkg::PRESCALE_DIV
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic       prescale_sel_i,
   input  wire logic       cascade_i,
   input  wire logic       timer1_ovf_i,
   input  wire logic       reload_wr_i,
   input  wire logic       counter_wr_i,
   input  wire logic       timer_mode_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] reload_o,
   output logic      [7:0] counter_o,
   output logic            overflow_o,
   output logic            toggle_o
);
   logic [4:0] pre_cnt;
   logic       tick;
   logic       pre_tick;
   assign pre_tick = (pre_cnt == 5'(PRE_DIV - 1));
   always_ff @(posedge clk_i) begin
      if (rst_i || pre_tick) begin
         pre_cnt <= 5'h00;
      end else begin
         pre_cnt <= pre_cnt + 5'h01;
      end
   end
   // source select: cascade from timer1, else /12 or undivided
   always_comb begin
      if (cascade_i) begin
         tick = timer1_ovf_i;
      end else if (prescale_sel_i) begin
         tick = 1'b1;
      end else begin
         tick = pre_tick;
      end
   end
   assign overflow_o = run_i && tick && (counter_o == spb_pkg::RATE_MAX);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_o <= spb_pkg::RATE_RST;
      end else if (reload_wr_i) begin
         reload_o <= wdata_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_o <= spb_pkg::RATE_RST;
      end else if (counter_wr_i || (reload_wr_i && !timer_mode_i)) begin
         counter_o <= wdata_i;
      end else if (overflow_o) begin
         counter_o <= reload_o;
      end else if (run_i && tick) begin
         counter_o <= counter_o + 8'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         toggle_o <= 1'b0;
      end else if (overflow_o) begin
         toggle_o <= ~toggle_o;
      end
   end
endmodule

/* File: spb_serial_core.sv */
// port-b serial port: spi master mode, timer mode, edge detect, uart0 rate feed
module spb_serial_core #(
   parameter int unsigned DATA_W = spb_pkg::DATA_W
) (
   input  wire logic              CORE_CLK_I,
   input  wire logic              RST_I,
   input  wire logic              MODE_SEL_BIT3_I,
   input  wire logic              MODE_SEL_BIT0_I,
   input  wire logic              MODE_SEL_BIT1_I,
   input  wire logic              SPI_SPEED_SEL_I,
   input  wire logic              BIT_ORDER_WR_I,
   input  wire logic              BIT_ORDER_SEL_I,
   input  wire logic              GEN_TIMER_MODE_EN_I,
   input  wire logic              RATE_GEN_RUN_I,
   input  wire logic              RATE_PRESCALE_SEL_I,
   input  wire logic              MULTIPROC_EN_I,
   input  wire logic              CLK_OUT_ENABLE_I,
   input  wire logic              RX_ENABLE_I,
   input  wire logic              TX_NINTH_BIT_I,
   input  wire logic              RX_NINTH_BIT_I,
   input  wire logic              TX_PIN_LATCH_I,
   input  wire logic              BUF_WR_I,
   input  wire logic [DATA_W-1:0] BUF_WDATA_I,
   input  wire logic              RELOAD_WR_I,
   input  wire logic              COUNTER_WR_I,
   input  wire logic [7:0]        RATE_WDATA_I,
   input  wire logic              TX_DONE_CLR_I,
   input  wire logic              RX_DONE_CLR_I,
   input  wire logic              POWER_DOWN_I,
   input  wire logic              TIMER1_OVERFLOW_I,
   input  wire logic              UART0_TX_CLK_SEL_I,
   input  wire logic              UART0_RX_CLK_SEL_I,
   input  wire logic              UART0_RATE_SRC_SEL_I,
   input  wire logic              UART0_DOUBLE_RATE_I,
   input  wire logic              UART0_QUAD_RATE_I,
   input  wire logic              MASTER_IN_PIN_I,
   input  wire logic              PORT_B_RX_PIN_I,
   output logic                   PORT_B_TX_PIN_O,
   output logic                   PORT_B_RX_PIN_O,
   output logic                   PORT_B_RX_PIN_OE_N_O,
   output logic                   RATE_CLK_OUT_PIN_O,
   output logic                   RATE_CLK_OUT_OE_N_O,
   output logic [DATA_W-1:0]      SERIAL_BUFFER_O,
   output logic                   BIT_ORDER_SEL_O,
   output logic                   TX_DONE_FLAG_O,
   output logic                   RX_DONE_FLAG_O,
   output logic                   SPI_BUSY_O,
   output logic                   SERIAL_IRQ_O,
   output logic                   WAKE_O,
   output logic [7:0]             RATE_RELOAD_O,
   output logic [7:0]             RATE_COUNTER_O,
   output logic                   RATE_OVERFLOW_O,
   output logic                   UART0_RATE_TICK_O
);
   logic [2:0]        mode;
   logic              spi_mode;
   logic              tmode;
   logic              bit_order;
   logic [3:0]        half_cnt;
   logic              half_tick;
   logic [3:0]        bit_cnt;
   logic [DATA_W-1:0] shreg;
   logic              sclk;
   logic              mosi;
   logic              spi_done;
   logic              take_miso;
   logic              miso_s1, miso_s2;
   logic              rx_s1, rx_s2, rx_d;
   logic              edge_hit;
   logic              gen_toggle;
   logic              gen_ovf;
   logic [4:0]        u0_cnt;
   logic [4:0]        u0_limit;
   spb_pkg::spb_state_e state;

   assign mode     = {MODE_SEL_BIT3_I, MODE_SEL_BIT0_I, MODE_SEL_BIT1_I};
   // timer mode takes precedence and frees the generator from the port
   assign tmode    = GEN_TIMER_MODE_EN_I;
   assign spi_mode = (mode == spb_pkg::MODE_SPI) && !tmode;

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         bit_order <= spb_pkg::BIT_ORDER_RST;
      end else if (BIT_ORDER_WR_I) begin
         bit_order <= BIT_ORDER_SEL_I;
      end
   end
   assign BIT_ORDER_SEL_O = bit_order;

   // pins are asynchronous: two flops before use
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         miso_s1 <= 1'b0;
         miso_s2 <= 1'b0;
         rx_s1   <= 1'b1;
         rx_s2   <= 1'b1;
         rx_d    <= 1'b1;
      end else begin
         miso_s1 <= MASTER_IN_PIN_I;
         miso_s2 <= miso_s1;
         rx_s1   <= PORT_B_RX_PIN_I;
         rx_s2   <= rx_s1;
         rx_d    <= rx_s2;
      end
   end

   // half-period divider: full period is 4 or 12 system clocks
   assign half_tick = (half_cnt == 4'(((SPI_SPEED_SEL_I ? spb_pkg::SPI_DIV_FAST
                                         : spb_pkg::SPI_DIV_SLOW) / 2) - 1));
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I || state == spb_pkg::SPB_IDLE || half_tick) begin
         half_cnt <= 4'h0;
      end else begin
         half_cnt <= half_cnt + 4'h1;
      end
   end

   // leading half: clock at idle level, trailing half: inverted
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         state     <= spb_pkg::SPB_IDLE;
         bit_cnt   <= 4'h0;
         shreg     <= '0;
         mosi      <= 1'b1;
         spi_done  <= 1'b0;
         take_miso <= 1'b0;
      end else begin
         spi_done  <= 1'b0;
         take_miso <= 1'b0;
         // synchroniser delay: miso is taken one clock after the rising pin edge
         if (take_miso) begin
            shreg <= bit_order ? {miso_s2, shreg[DATA_W-1:1]}
                               : {shreg[DATA_W-2:0], miso_s2};
         end
         unique case (state)
            spb_pkg::SPB_IDLE: begin
               if (BUF_WR_I && spi_mode) begin
                  state   <= spb_pkg::SPB_LOW;
                  shreg   <= BUF_WDATA_I;
                  bit_cnt <= 4'h0;
                  mosi    <= bit_order ? BUF_WDATA_I[0] : BUF_WDATA_I[DATA_W-1];
               end else if (BUF_WR_I) begin
                  shreg <= BUF_WDATA_I;
               end
            end
            spb_pkg::SPB_LOW: begin
               if (half_tick) begin
                  state     <= spb_pkg::SPB_HIGH;
                  take_miso <= !TX_PIN_LATCH_I;
                  if (TX_PIN_LATCH_I && bit_cnt != 4'h0) begin
                     mosi <= bit_order ? shreg[0] : shreg[DATA_W-1];
                  end
               end
            end
            spb_pkg::SPB_HIGH: begin
               if (half_tick) begin
                  take_miso <= TX_PIN_LATCH_I;
                  if (bit_cnt == spb_pkg::BITS_LAST) begin
                     state    <= spb_pkg::SPB_IDLE;
                     spi_done <= 1'b1;
                  end else begin
                     state   <= spb_pkg::SPB_LOW;
                     bit_cnt <= bit_cnt + 4'h1;
                     if (!TX_PIN_LATCH_I) begin
                        mosi <= bit_order ? shreg[0] : shreg[DATA_W-1];
                     end
                  end
               end
            end
            default: state <= spb_pkg::SPB_IDLE;
         endcase
      end
   end
   assign SPI_BUSY_O      = (state != spb_pkg::SPB_IDLE);
   assign SERIAL_BUFFER_O = shreg;

   // polarity from the port latch covers spi modes 0 and 3: data is always taken on the rising clock edge
   assign sclk = (state == spb_pkg::SPB_HIGH) ? ~TX_PIN_LATCH_I : TX_PIN_LATCH_I;
   assign PORT_B_TX_PIN_O      = spi_mode ? sclk : TX_PIN_LATCH_I;
   assign PORT_B_RX_PIN_O      = mosi;
   assign PORT_B_RX_PIN_OE_N_O = ~spi_mode;

   spb_rate_gen #(
      .PRE_DIV (spb_pkg::PRESCALE_DIV)
   ) u_rate (
      .clk_i          (CORE_CLK_I),
      .rst_i          (RST_I),
      .run_i          (RATE_GEN_RUN_I),
      .prescale_sel_i (RATE_PRESCALE_SEL_I),
      .cascade_i      (tmode && MULTIPROC_EN_I && !RATE_PRESCALE_SEL_I),
      .timer1_ovf_i   (TIMER1_OVERFLOW_I),
      .reload_wr_i    (RELOAD_WR_I),
      .counter_wr_i   (COUNTER_WR_I),
      .timer_mode_i   (tmode),
      .wdata_i        (RATE_WDATA_I),
      .reload_o       (RATE_RELOAD_O),
      .counter_o      (RATE_COUNTER_O),
      .overflow_o     (gen_ovf),
      .toggle_o       (gen_toggle)
   );
   assign RATE_OVERFLOW_O     = gen_ovf;
   assign RATE_CLK_OUT_PIN_O  = gen_toggle;
   assign RATE_CLK_OUT_OE_N_O = ~CLK_OUT_ENABLE_I;

   // power-down: level compare instead of edge
   always_comb begin
      if (POWER_DOWN_I) begin
         edge_hit = RX_NINTH_BIT_I ? rx_s2 : ~rx_s2;
      end else begin
         edge_hit = RX_NINTH_BIT_I ? (rx_s2 && !rx_d) : (!rx_s2 && rx_d);
      end
   end

   // set beats clear on the same cycle
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         TX_DONE_FLAG_O <= 1'b0;
      end else if (spi_done || (tmode && gen_ovf)) begin
         TX_DONE_FLAG_O <= 1'b1;
      end else if (TX_DONE_CLR_I) begin
         TX_DONE_FLAG_O <= 1'b0;
      end
   end
   // spi transfers have no path to this flag
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         RX_DONE_FLAG_O <= 1'b0;
      end else if (tmode && RX_ENABLE_I && edge_hit) begin
         RX_DONE_FLAG_O <= 1'b1;
      end else if (RX_DONE_CLR_I) begin
         RX_DONE_FLAG_O <= 1'b0;
      end
   end

   always_comb begin
      if (tmode) begin
         SERIAL_IRQ_O = (TX_DONE_FLAG_O && TX_NINTH_BIT_I)
                      || (RX_DONE_FLAG_O && RX_ENABLE_I && !CLK_OUT_ENABLE_I);
      end else begin
         SERIAL_IRQ_O = TX_DONE_FLAG_O || RX_DONE_FLAG_O;
      end
   end
   assign WAKE_O = POWER_DOWN_I && SERIAL_IRQ_O;

   // uart0 16x sample tick: /32 base, /16 double, /8 quad, /4 both
   always_comb begin
      u0_limit = 5'(spb_pkg::UART_DIV - 1);
      if (UART0_DOUBLE_RATE_I) begin
         u0_limit = 5'(spb_pkg::UART_DIV / 2 - 1);
      end
      if (UART0_QUAD_RATE_I) begin
         u0_limit = UART0_DOUBLE_RATE_I ? 5'(spb_pkg::UART_DIV / 8 - 1)
                                        : 5'(spb_pkg::UART_DIV / 4 - 1);
      end
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         u0_cnt <= 5'h00;
      end else if (gen_ovf) begin
         u0_cnt <= (u0_cnt >= u0_limit) ? 5'h00 : u0_cnt + 5'h01;
      end
   end
   assign UART0_RATE_TICK_O = gen_ovf && (u0_cnt >= u0_limit) && !UART0_TX_CLK_SEL_I
                            && !UART0_RX_CLK_SEL_I && UART0_RATE_SRC_SEL_I;

   property p_order_reset;
      @(posedge CORE_CLK_I) $fell(RST_I) |-> bit_order;
   endproperty
   a_order_reset: assert property (p_order_reset) else $error("bit order not lsb after reset");

   property p_start;
      @(posedge CORE_CLK_I) disable iff (RST_I)
         (state == spb_pkg::SPB_IDLE && BUF_WR_I && spi_mode) |=> SPI_BUSY_O;
   endproperty
   a_start: assert property (p_start) else $error("buffer write did not start");

   property p_done_fast;
      @(posedge CORE_CLK_I) disable iff (RST_I)
         (state == spb_pkg::SPB_IDLE && BUF_WR_I && spi_mode && SPI_SPEED_SEL_I)
         ##1 SPI_SPEED_SEL_I [*8] |-> ##[24:26] TX_DONE_FLAG_O;
   endproperty
   a_done_fast: assert property (p_done_fast) else $error("fast transfer not done in time");

   property p_no_rx_spi;
      @(posedge CORE_CLK_I) disable iff (RST_I) spi_mode && !$past(tmode) |=> !$rose(RX_DONE_FLAG_O);
   endproperty
   a_no_rx_spi: assert property (p_no_rx_spi) else $error("rx done set in spi mode");

   property p_tovf;
      @(posedge CORE_CLK_I) disable iff (RST_I) tmode && gen_ovf |=> TX_DONE_FLAG_O;
   endproperty
   a_tovf: assert property (p_tovf) else $error("overflow did not set tx done");

   property p_reload;
      @(posedge CORE_CLK_I) disable iff (RST_I)
         gen_ovf && !RELOAD_WR_I && !COUNTER_WR_I |=> RATE_COUNTER_O == $past(RATE_RELOAD_O);
   endproperty
   a_reload: assert property (p_reload) else $error("counter not reloaded");

   property p_stop;
      @(posedge CORE_CLK_I) disable iff (RST_I)
         !RATE_GEN_RUN_I && !RELOAD_WR_I && !COUNTER_WR_I |=> $stable(RATE_COUNTER_O);
   endproperty
   a_stop: assert property (p_stop) else $error("counter moved while stopped");

   property p_irq_mask;
      @(posedge CORE_CLK_I) disable iff (RST_I)
         tmode && CLK_OUT_ENABLE_I && !TX_DONE_FLAG_O |-> !SERIAL_IRQ_O;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("edge irq not masked");

   property p_idle_clk;
      @(posedge CORE_CLK_I) disable iff (RST_I)
         spi_mode && !SPI_BUSY_O |-> PORT_B_TX_PIN_O == TX_PIN_LATCH_I;
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("clock not at idle level");
endmodule

/* File: spb_spi_slave.sv */
// behavioural spi slave standing on the port-b pins
module spb_spi_slave (
   input  wire logic       sclk_i,
   input  wire logic       ss_n_i,
   input  wire logic       mosi_i,
   input  wire logic       lsb_first_i,
   input  wire logic [7:0] tx_byte_i,
   output logic            miso_o,
   output logic      [7:0] rx_byte_o,
   output int              rises_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      miso_o = 1'h0;
      rx_byte_o = 8'h00;
      rises_o = 0;
   end
   // sample on rising edges only, whatever the idle level
   always @(posedge sclk_i or posedge ss_n_i) begin
      if (ss_n_i) begin
         rises_o <= 0;
      end else begin
         rises_o <= rises_o + 1;
         rx_byte_o <= lsb_first_i ? {mosi_i, rx_byte_o[7:1]} : {rx_byte_o[6:0], mosi_i};
      end
   end
   // no pull on miso: a released line shows the inverse, never a held value
   always @(negedge sclk_i or negedge ss_n_i or posedge ss_n_i) begin
      if (ss_n_i) begin
         miso_o <= ~miso_o;
      end else if (rises_o < 8) begin
         miso_o <= lsb_first_i ? tx_byte_i[rises_o] : tx_byte_i[7 - rises_o];
      end
   end
endmodule

/* File: serial_port1_spi_master_brg_tb.sv */
// self-checking bench for the port-b spi master and rate generator
module serial_port1_spi_master_brg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'h0, rst = 1'h1, m3 = 1'h0, m0 = 1'h0, m1 = 1'h0, spd = 1'h0;
   logic       bo_wr = 1'h0, bo_sel = 1'h1, tmode = 1'h0, run = 1'h0, pre = 1'h0, mp = 1'h0;
   logic       cko = 1'h0, ren = 1'h0, tb8 = 1'h0, rb8 = 1'h0, latch = 1'h0, bwr = 1'h0;
   logic       rlwr = 1'h0, cnwr = 1'h0, tclr = 1'h0, rclr = 1'h0, pd = 1'h0, t1ovf = 1'h0;
   logic       u_tc = 1'h0, u_rc = 1'h0, u_src = 1'h0, u_dbl = 1'h0, u_quad = 1'h0;
   logic       rx_drv = 1'h1, ss_n = 1'h1, s_lsb = 1'h1, p;
   logic [7:0] bdat = 8'h00, rdat = 8'h00, s_tx = 8'h00, c8;
   logic       sclk, mosi, mosi_oe_n, cko_pin, cko_oe_n, bo_q, tdone, rdone, busy, irq, wake;
   logic       ovf, utick, miso, rx_wire;
   logic [7:0] buf_q, rl_q, cn_q, s_rx;
   int         s_rises, n, miscompares = 0, check_count = 0;

   always #2 clk = ~clk;
   // shared rx pin: design drives it as mosi, otherwise the bench does
   assign rx_wire = mosi_oe_n ? rx_drv : mosi;

   spb_serial_core dut (
      .CORE_CLK_I(clk), .RST_I(rst), .MODE_SEL_BIT3_I(m3), .MODE_SEL_BIT0_I(m0),
      .MODE_SEL_BIT1_I(m1), .SPI_SPEED_SEL_I(spd), .BIT_ORDER_WR_I(bo_wr),
      .BIT_ORDER_SEL_I(bo_sel), .GEN_TIMER_MODE_EN_I(tmode), .RATE_GEN_RUN_I(run),
      .RATE_PRESCALE_SEL_I(pre), .MULTIPROC_EN_I(mp), .CLK_OUT_ENABLE_I(cko),
      .RX_ENABLE_I(ren), .TX_NINTH_BIT_I(tb8), .RX_NINTH_BIT_I(rb8), .TX_PIN_LATCH_I(latch),
      .BUF_WR_I(bwr), .BUF_WDATA_I(bdat), .RELOAD_WR_I(rlwr), .COUNTER_WR_I(cnwr),
      .RATE_WDATA_I(rdat), .TX_DONE_CLR_I(tclr), .RX_DONE_CLR_I(rclr), .POWER_DOWN_I(pd),
      .TIMER1_OVERFLOW_I(t1ovf), .UART0_TX_CLK_SEL_I(u_tc), .UART0_RX_CLK_SEL_I(u_rc),
      .UART0_RATE_SRC_SEL_I(u_src), .UART0_DOUBLE_RATE_I(u_dbl), .UART0_QUAD_RATE_I(u_quad),
      .MASTER_IN_PIN_I(miso), .PORT_B_RX_PIN_I(rx_wire), .PORT_B_TX_PIN_O(sclk),
      .PORT_B_RX_PIN_O(mosi), .PORT_B_RX_PIN_OE_N_O(mosi_oe_n), .RATE_CLK_OUT_PIN_O(cko_pin),
      .RATE_CLK_OUT_OE_N_O(cko_oe_n), .SERIAL_BUFFER_O(buf_q), .BIT_ORDER_SEL_O(bo_q),
      .TX_DONE_FLAG_O(tdone), .RX_DONE_FLAG_O(rdone), .SPI_BUSY_O(busy), .SERIAL_IRQ_O(irq),
      .WAKE_O(wake), .RATE_RELOAD_O(rl_q), .RATE_COUNTER_O(cn_q), .RATE_OVERFLOW_O(ovf),
      .UART0_RATE_TICK_O(utick)
   );

   spb_spi_slave slave (
      .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(rx_wire), .lsb_first_i(s_lsb),
      .tx_byte_i(s_tx), .miso_o(miso), .rx_byte_o(s_rx), .rises_o(s_rises)
   );

   task automatic final_report;
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic pulse(ref logic s);
      s = 1'h1;
      @(negedge clk);
      s = 1'h0;
   endtask

   // 0 tx done, 1 overflow, 2 uart0 tick, 3 rx done; n = falling edges waited
   task automatic wait_sig(input int sel, input int lim, output int cnt);
      logic s;
      cnt = 0;
      do begin
         @(negedge clk);
         cnt++;
         s = (sel == 0) ? tdone : (sel == 1) ? ovf : (sel == 2) ? utick : rdone;
      end while (s !== 1'h1 && cnt < lim);
      if (s !== 1'h1) begin
         miscompares++;
         $display("BAD t=%0t timeout sel=%h", $time, sel);
         final_report();
      end
   endtask

   task automatic spi_xfer(input logic [7:0] tx, input logic [7:0] sv, input logic f,
                           input logic pol);
      int lim;
      lim = f ? spb_pkg::SPI_DIV_FAST * 8 : spb_pkg::SPI_DIV_SLOW * 8;
      spd = f;
      latch = pol;
      s_tx = sv;
      @(negedge clk);
      ss_n = 1'h0;
      @(negedge clk);
      bdat = tx;
      bwr = 1'h1;
      @(negedge clk);
      chk(busy, 1'h1);
      // strobe held: the second write lands while busy and must be ignored
      bdat = ~tx;
      @(negedge clk);
      bwr = 1'h0;
      wait_sig(0, 200, n);
      chk((n + 1 >= lim - 1) && (n + 1 <= lim + 3), 1'h1);
      chk(s_rx, tx);
      chk({buf_q, s_rises[7:0]}, {sv, 8'h08});
      chk(rdone, 1'h0);
      repeat (14) @(negedge clk);
      chk(sclk, pol);
      ss_n = 1'h1;
      pulse(tclr);
      chk(tdone, 1'h0);
   endtask

   initial begin
      repeat (3) @(negedge clk);
      rst = 1'h0;
      chk(bo_q, spb_pkg::BIT_ORDER_RST);
      chk({tdone, rdone, rl_q, cn_q}, 18'h0);
      for (int i = 0; i < 8; i++) begin
         {m3, m0, m1} = i[2:0];
         latch = i[0];
         @(negedge clk);
         chk(mosi_oe_n, i != 4);
         if (i != 4) begin
            chk(sclk, latch);
         end
      end
      {m3, m0, m1} = spb_pkg::MODE_SPI;
      for (int i = 0; i < 4; i++) begin
         if (i == 2) begin
            bo_sel = 1'h0;
            pulse(bo_wr);
            s_lsb = 1'h0;
            chk(bo_q, 1'h0);
         end
         spi_xfer(8'h35 + 8'(i * 37), 8'hC9 - 8'(i * 21), i[0], i[1]);
      end
      tmode = 1'h1;
      pulse(bwr);
      chk(busy, 1'h0);
      pre = 1'h1;
      rdat = 8'hFD;
      pulse(rlwr);
      chk({rl_q, cn_q}, 16'hFD00);
      pulse(cnwr);
      cko = 1'h1;
      run = 1'h1;
      wait_sig(1, 300, n);
      wait_sig(1, 20, n);
      chk(n, 3);
      chk(tdone, 1'h1);
      p = cko_pin;
      @(negedge clk);
      chk({cko_oe_n, cko_pin, cn_q}, {1'h0, ~p, 8'hFD});
      pre = 1'h0;
      wait_sig(1, 100, n);
      wait_sig(1, 100, n);
      chk(n, spb_pkg::PRESCALE_DIV * 3);
      run = 1'h0;
      @(negedge clk);
      c8 = cn_q;
      repeat (40) @(negedge clk);
      chk(cn_q, c8);
      mp = 1'h1;
      run = 1'h1;
      pulse(cnwr);
      repeat (40) @(negedge clk);
      chk(cn_q, 8'hFD);
      for (int i = 0; i < 2; i++) begin
         pulse(t1ovf);
         @(negedge clk);
      end
      chk(cn_q, 8'hFF);
      t1ovf = 1'h1;
      #1;
      chk(ovf, 1'h1);
      @(negedge clk);
      {cko, t1ovf, run, mp, pre} = 5'h01;
      pulse(tclr);
      ren = 1'h1;
      pulse(rclr);
      rx_drv = 1'h0;
      wait_sig(3, 8, n);
      chk(irq, 1'h1);
      cko = 1'h1;
      @(negedge clk);
      chk({irq, cko_oe_n}, 2'h0);
      {cko, ren} = 2'h0;
      @(negedge clk);
      chk(irq, 1'h0);
      ren = 1'h1;
      pulse(rclr);
      rx_drv = 1'h1;
      repeat (8) @(negedge clk);
      chk(rdone, 1'h0);
      {rb8, rx_drv} = 2'h2;
      repeat (8) @(negedge clk);
      chk(rdone, 1'h0);
      rx_drv = 1'h1;
      wait_sig(3, 8, n);
      pulse(rclr);
      run = 1'h1;
      wait_sig(0, 300, n);
      chk(irq, 1'h0);
      tb8 = 1'h1;
      @(negedge clk);
      chk(irq, 1'h1);
      {run, tb8, rb8, rx_drv, pd} = 5'h01;
      pulse(tclr);
      wait_sig(3, 8, n);
      chk(wake, 1'h1);
      pulse(rclr);
      wait_sig(3, 8, n);
      {pd, rx_drv, tmode} = 3'h2;
      pulse(rlwr);
      chk(cn_q, 8'hFD);
      {u_src, run} = 2'h3;
      for (int k = 0; k < 4; k++) begin
         {u_quad, u_dbl} = k[1:0];
         wait_sig(2, 400, n);
         wait_sig(2, 400, n);
         chk(n, 3 * (spb_pkg::UART_DIV >> (k[0] + 2 * k[1])));
      end
      for (int j = 0; j < 3; j++) begin
         {u_src, u_rc, u_tc} = (j == 0) ? 3'h6 : (j == 1) ? 3'h5 : 3'h0;
         n = 0;
         repeat (200) begin
            @(negedge clk);
            n += (utick === 1'h1);
         end
         chk(n, 0);
      end
      final_report();
   end
endmodule
